// ==== design/ctrs_capture_route.v ====
// Purpose: Capture channel output path to the routing unit, with status
// Assumes: Fast capture clock; routing side answers a toggle handshake
// Notes:   Capture and routing share the clock port; routing ack arrives
//          as a toggle and is synchronised before use
//
// Behaviour
// - With routing enabled, each capture is offered as request, words, control bits.
// - Control bit 1 flags overflow while pending; bit 2 flags timeout.
// - Fast cluster clock must still deliver true values of control bits 2,1.
// - Capture channel runs on its cluster clock.
// - Request stays pending until acknowledged, at least one round trip.
// - Control bit 0 shows new level if capture lands just before ack.
// - Late capture updates overflow bit and selected words consistently.
// - Overflow and timeout readable in notify bits 3 and 4.
// - Level embedded in data words via edge count or level select is correct.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ctrs_consts.vh"
module ctrs_capture_route #(
    parameter DW = 24
) (
    // Clock and reset
    input  wire          clock,
    input  wire          rst,
    // APB slave
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [11:0]   paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output reg           pready,
    output reg           pslverr,
    // Capture channel events
    input  wire          captureEvent,
    input  wire          timeoutEvent,
    input  wire          inputLevel,
    input  wire [DW-1:0] captureValue,
    input  wire [DW-1:0] timeBase,
    // Routing unit bundle
    output reg           routeReqToggle,
    output reg  [DW-1:0] routeData0,
    output reg  [DW-1:0] routeData1,
    output reg  [2:0]    arrivalControlBits,
    input  wire          routeAckToggle,
    // Interrupt
    output reg           irq
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg  [31:0]                ctrl_q;
    reg  [`CTRS_NTF_WIDTH-1:0] notify_q;
    reg  [`CTRS_NTF_WIDTH-1:0] irqEn_q;
    reg  [DW-1:0]              edgeCnt_q;
    reg                        pending_q;
    reg                        queued_q;
    reg                        ackSeen_q;
    reg  [DW-1:0]              word0_q;
    reg  [DW-1:0]              word1_q;
    reg  [2:0]                 acb_q;
    reg                        lastLevel_q;
    wire                       ackSync;
    wire                       routeEn;
    wire [1:0]                 sel0;
    wire [1:0]                 sel1;
    wire                       ackPulse;
    wire                       inFlight;
    wire                       sendNow;
    wire                       routeCapture;
    wire                       routeTimeout;
    wire                       routeEvent;
    wire [DW-1:0]              nextEdgeCnt;
    reg  [DW-1:0]              newWord0;
    reg  [DW-1:0]              newWord1;
    wire                       apbSetup;
    wire                       apbWr;
    wire                       apbRd;
    wire                       hitCtrl;
    wire                       hitIrqEn;
    wire                       hitIrqClr;
    wire                       wrAllowed;
    wire [`CTRS_NTF_WIDTH-1:0] clrMask;
    wire [`CTRS_NTF_WIDTH-1:0] notifyNext;
    reg  [`CTRS_NTF_WIDTH-1:0] setMask;
    reg  [31:0]                rdMux;
    reg                        rdErr;

    // ----------------------------------------
    // Control decode
    // ----------------------------------------
    assign routeEn      = ctrl_q[`CTRS_CTRL_ROUTE_EN];
    assign sel0         = ctrl_q[`CTRS_CTRL_SEL0_LO+1:`CTRS_CTRL_SEL0_LO];
    assign sel1         = ctrl_q[`CTRS_CTRL_SEL1_LO+1:`CTRS_CTRL_SEL1_LO];
    assign routeCapture = routeEn && captureEvent;
    assign routeTimeout = routeEn && timeoutEvent;
    assign routeEvent   = routeCapture || routeTimeout;
    assign nextEdgeCnt  = edgeCnt_q + {{(DW-1){1'b0}}, 1'b1};

    // ----------------------------------------
    // Handshake state
    // ----------------------------------------
    // Sent bundle still waiting for the far end
    assign inFlight = routeReqToggle != ackSeen_q;
    assign ackPulse = pending_q && (ackSync != ackSeen_q);
    assign sendNow  = pending_q && !inFlight && !ackPulse;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign apbSetup  = psel && !penable;
    assign apbWr     = psel && penable && pwrite && pready;
    assign apbRd     = apbSetup && !pwrite;
    assign hitCtrl   = paddr == `CTRS_OFS_CTRL;
    assign hitIrqEn  = paddr == `CTRS_OFS_IRQ_EN;
    assign hitIrqClr = paddr == `CTRS_OFS_IRQ_CLR;
    assign wrAllowed = hitCtrl || hitIrqEn || hitIrqClr;
    assign clrMask   = (apbWr && hitIrqClr) ?
                       pwdata[`CTRS_NTF_WIDTH-1:0] : {`CTRS_NTF_WIDTH{1'b0}};

    // ----------------------------------------
    // Acknowledge synchroniser
    // ----------------------------------------
    ctrs_sync_bit u_ackSync (
        .clock   (clock),
        .rst     (rst),
        .asyncIn (routeAckToggle),
        .syncOut (ackSync)
    );

    // ----------------------------------------
    // Data word selection
    // ----------------------------------------
    // Edge count carries the level in bit 0
    always @* begin
        case (sel0)
            `CTRS_SEL_CAPTURE: newWord0 = captureValue;
            `CTRS_SEL_EDGECNT: begin
                newWord0 = {nextEdgeCnt[DW-1:1], inputLevel};
            end
            `CTRS_SEL_LEVEL: begin
                newWord0 = {{(DW-1){1'b0}}, inputLevel};
            end
            default: newWord0 = timeBase;
        endcase
    end

    always @* begin
        case (sel1)
            `CTRS_SEL_CAPTURE: newWord1 = captureValue;
            `CTRS_SEL_EDGECNT: begin
                newWord1 = {nextEdgeCnt[DW-1:1], inputLevel};
            end
            `CTRS_SEL_LEVEL: begin
                newWord1 = {{(DW-1){1'b0}}, inputLevel};
            end
            default: newWord1 = timeBase;
        endcase
    end

    // ----------------------------------------
    // Edge counter and last level
    // ----------------------------------------
    always @(posedge clock) begin
        if (rst) begin
            edgeCnt_q   <= {DW{1'b0}};
            lastLevel_q <= 1'b0;
        end else if (captureEvent) begin
            edgeCnt_q   <= nextEdgeCnt;
            lastLevel_q <= inputLevel;
        end
    end

    // ----------------------------------------
    // Acknowledge bookkeeping
    // ----------------------------------------
    always @(posedge clock) begin
        if (rst) begin
            ackSeen_q <= 1'b0;
        end else if (ackPulse) begin
            ackSeen_q <= ackSync;
        end
    end

    // ----------------------------------------
    // Capture bundle
    // ----------------------------------------
    always @(posedge clock) begin
        if (rst) begin
            word0_q <= {DW{1'b0}};
            word1_q <= {DW{1'b0}};
            acb_q   <= 3'h0;
        end else if (routeCapture) begin
            // Late capture overrides the acknowledged bundle
            word0_q  <= newWord0;
            word1_q  <= newWord1;
            acb_q[0] <= inputLevel;
            acb_q[1] <= pending_q && !ackPulse;
            acb_q[2] <= timeoutEvent;
        end else if (routeTimeout) begin
            acb_q[2] <= 1'b1;
            if (!pending_q || ackPulse) begin
                acb_q[0] <= lastLevel_q;
                acb_q[1] <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Pending request
    // ----------------------------------------
    // An event after the send is queued so the ack cannot drop it
    always @(posedge clock) begin
        if (rst) begin
            pending_q <= 1'b0;
            queued_q  <= 1'b0;
        end else begin
            if (routeEvent && (inFlight || sendNow)) begin
                queued_q <= 1'b1;
            end else if (sendNow) begin
                queued_q <= 1'b0;
            end
            if (routeEvent) begin
                pending_q <= 1'b1;
            end else if (ackPulse) begin
                pending_q <= queued_q;
            end
        end
    end

    // ----------------------------------------
    // Routing handshake, whole bundle at once
    // ----------------------------------------
    always @(posedge clock) begin
        if (rst) begin
            routeReqToggle     <= 1'b0;
            routeData0         <= {DW{1'b0}};
            routeData1         <= {DW{1'b0}};
            arrivalControlBits <= 3'h0;
        end else if (sendNow) begin
            // Bundle is frozen until the far end toggles back
            routeData0         <= word0_q;
            routeData1         <= word1_q;
            arrivalControlBits <= acb_q;
            routeReqToggle     <= ~routeReqToggle;
        end
    end

    // ----------------------------------------
    // Notify status, set wins over clear
    // ----------------------------------------
    always @* begin
        setMask = {`CTRS_NTF_WIDTH{1'b0}};
        setMask[`CTRS_NTF_NEWVAL]   = captureEvent;
        setMask[`CTRS_NTF_ACKED]    = ackPulse;
        setMask[`CTRS_NTF_LEVEL]    = captureEvent && inputLevel;
        setMask[`CTRS_NTF_OVERFLOW] = captureEvent && pending_q
                                      && !ackPulse;
        setMask[`CTRS_NTF_TIMEOUT]  = timeoutEvent;
    end

    assign notifyNext = (notify_q & ~clrMask) | setMask;

    always @(posedge clock) begin
        if (rst) begin
            notify_q <= {`CTRS_NTF_WIDTH{1'b0}};
        end else begin
            notify_q <= notifyNext;
        end
    end

    // ----------------------------------------
    // Level interrupt
    // ----------------------------------------
    always @(posedge clock) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(notifyNext & irqEn_q);
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    always @* begin
        rdErr = 1'b0;
        case (paddr)
            `CTRS_OFS_CTRL:    rdMux = ctrl_q;
            `CTRS_OFS_NOTIFY:  rdMux = {{(32-`CTRS_NTF_WIDTH){1'b0}},
                                       notify_q};
            `CTRS_OFS_IRQ_EN:  rdMux = {{(32-`CTRS_NTF_WIDTH){1'b0}},
                                       irqEn_q};
            `CTRS_OFS_IRQ_CLR: rdMux = 32'h0000_0000;
            `CTRS_OFS_LEVEL:   rdMux = {30'h000_0000, pending_q,
                                       lastLevel_q};
            `CTRS_OFS_DATA0:   rdMux = {{(32-DW){1'b0}}, word0_q};
            `CTRS_OFS_DATA1:   rdMux = {{(32-DW){1'b0}}, word1_q};
            default: begin
                rdMux = 32'h0000_0000;
                rdErr = 1'b1;
            end
        endcase
    end

    // ----------------------------------------
    // Bus response
    // ----------------------------------------
    always @(posedge clock) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= apbSetup;
            pslverr <= 1'b0;
            if (apbRd) begin
                prdata <= rdMux;
            end
            if (apbSetup) begin
                pslverr <= pwrite ? !wrAllowed : rdErr;
            end
        end
    end

    // ----------------------------------------
    // Writable registers
    // ----------------------------------------
    always @(posedge clock) begin
        if (rst) begin
            ctrl_q  <= `CTRS_CTRL_RESET;
            irqEn_q <= {`CTRS_NTF_WIDTH{1'b0}};
        end else begin
            if (apbWr && hitCtrl) begin
                ctrl_q <= {27'h000_0000, pwdata[4:0]};
            end
            if (apbWr && hitIrqEn) begin
                irqEn_q <= pwdata[`CTRS_NTF_WIDTH-1:0];
            end
        end
    end
endmodule
`default_nettype wire

// ==== design/ctrs_consts.vh ====
// Purpose: Constants of the capture-to-routing status block
// Assumes: 32-bit APB register words at byte addresses
// Notes:   Offsets are byte addresses
`ifndef CTRS_CONSTS_VH
`define CTRS_CONSTS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CTRS_OFS_CTRL     12'h000
`define CTRS_OFS_NOTIFY   12'h004
`define CTRS_OFS_IRQ_EN   12'h008
`define CTRS_OFS_IRQ_CLR  12'h00C
`define CTRS_OFS_LEVEL    12'h010
`define CTRS_OFS_DATA0    12'h014
`define CTRS_OFS_DATA1    12'h018
// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRS_CTRL_ROUTE_EN  0
`define CTRS_CTRL_SEL0_LO   1
`define CTRS_CTRL_SEL1_LO   3
`define CTRS_CTRL_RESET     32'h0000_0000
// ----------------------------------------
// Notify fields
// ----------------------------------------
`define CTRS_NTF_NEWVAL   0
`define CTRS_NTF_ACKED    1
`define CTRS_NTF_LEVEL    2
`define CTRS_NTF_OVERFLOW 3
`define CTRS_NTF_TIMEOUT  4
`define CTRS_NTF_WIDTH    5
// ----------------------------------------
// Data word selections
// ----------------------------------------
`define CTRS_SEL_CAPTURE  2'h0
`define CTRS_SEL_EDGECNT  2'h1
`define CTRS_SEL_LEVEL    2'h2
`define CTRS_SEL_TIMEBASE 2'h3
`endif

// ==== design/ctrs_sync_bit.v ====
// Purpose: Two-flop level synchroniser
// Assumes: Input comes from the other clock domain
// Notes:   First flop feeds only the second
`timescale 1ns/1ps
`default_nettype none
module ctrs_sync_bit (
    // Clock and reset
    input  wire clock,
    input  wire rst,
    // Level
    input  wire asyncIn,
    output reg  syncOut
);
    reg meta_q;
    always @(posedge clock) begin
        if (rst) begin
            meta_q  <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/ctrs_capture_route_assertions.sv ====
// Purpose: Port checks of the capture-to-routing block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the design below
`timescale 1ns/1ps
`default_nettype none
module ctrs_capture_route_assertions #(
    parameter int DW = 24
) (
    // Clock and reset
    input wire logic          clock,
    input wire logic          rst,
    // APB
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [11:0]   paddr,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    // Capture and routing
    input wire logic          captureEvent,
    input wire logic          inputLevel,
    input wire logic          routeReqToggle,
    input wire logic          routeAckToggle,
    input wire logic [DW-1:0] routeData0,
    input wire logic [DW-1:0] routeData1,
    input wire logic [2:0]    arrivalControlBits
);
    logic levelSeen_q;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // ----
    // Level of the latest capture
    // ----
    always_ff @(posedge clock) begin
        if (rst)
            levelSeen_q <= 1'b0;
        else if (captureEvent)
            levelSeen_q <= inputLevel;
    end
    sequence apbSetup;
        psel && !penable;
    endsequence
    ready_after_setup_a: assert property (apbSetup |=> pready)
        else $error("no pready after setup");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("pready too long");
    unmapped_err_a: assert property (apbSetup ##0 (paddr > 12'h018)
        |=> pslverr) else $error("unmapped not refused");
    err_reads_zero_a: assert property (pready && pslverr && !pwrite
        |-> prdata == 32'h0000_0000) else $error("refused read not zero");
    bundle_with_req_a: assert property (
        $changed({routeData0, routeData1, arrivalControlBits})
        |-> $changed(routeReqToggle)) else $error("bundle moved alone");
    req_after_ack_a: assert property ($changed(routeReqToggle)
        |-> $past(routeReqToggle == routeAckToggle, 2))
        else $error("request before ack");
    pending_held_a: assert property (
        routeReqToggle != routeAckToggle |=> $stable(routeReqToggle))
        else $error("request moved while pending");
    level_in_bundle_a: assert property (
        $changed(routeReqToggle) && !$past(captureEvent)
        |-> arrivalControlBits[0] == levelSeen_q)
        else $error("level bit stale");
endmodule
bind ctrs_capture_route ctrs_capture_route_assertions #(.DW(DW)) chk_i (.*);
`default_nettype wire

// ==== testbench/ctrs_route_model.sv ====
// Purpose: Routing-unit stand-in that acknowledges bundles
// Assumes: Toggle request, toggle acknowledge
// Notes:   Answer delay is set live by the bench
`timescale 1ns/1ps
`default_nettype none
module ctrs_route_model #(
    parameter int DW = 24
) (
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          rst,
    // Bundle in
    input  wire logic          reqToggle,
    input  wire logic [DW-1:0] data0,
    input  wire logic [2:0]    acb,
    input  wire logic [7:0]    delay,
    // Answer and last bundle taken
    output logic               ackToggle,
    output logic [DW-1:0]      gotData,
    output logic [2:0]         gotAcb,
    output logic [7:0]         gotCount
);
    logic [7:0] wait_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            ackToggle <= 1'b0;
            wait_q <= 8'h00;
            gotCount <= 8'h00;
            gotData <= '0;
            gotAcb <= 3'h0;
        end else if (reqToggle != ackToggle) begin
            wait_q <= wait_q + 8'h01;
            if (wait_q >= delay) begin
                ackToggle <= reqToggle;
                gotData <= data0;
                gotAcb <= acb;
                gotCount <= gotCount + 8'h01;
                wait_q <= 8'h00;
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Purpose: Self-checking bench of the capture-to-routing block
// Assumes: Zero-wait APB, routing stand-in on the far side
// Notes:   All drives follow the rising edge
`timescale 1ns/1ps
`default_nettype none
`include "ctrs_consts.vh"
module tb;
    logic        clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr, er, irq;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        captureEvent = 1'b0, timeoutEvent = 1'b0, inputLevel = 1'b0;
    logic [23:0] captureValue = 24'h00_0000, timeBase = 24'h00_0000;
    logic [23:0] routeData0, routeData1, gotData;
    logic        routeReqToggle, routeAckToggle;
    logic [2:0]  arrivalControlBits, gotAcb;
    logic [7:0]  gotCount, delay = 8'h02;
    int          errors = 0, cmp_count = 0;
    always #5 clock = ~clock;
    ctrs_capture_route #(.DW(24)) dut (.clock(clock), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .captureEvent(captureEvent),
        .timeoutEvent(timeoutEvent), .inputLevel(inputLevel),
        .captureValue(captureValue), .timeBase(timeBase),
        .routeReqToggle(routeReqToggle), .routeData0(routeData0),
        .routeData1(routeData1), .arrivalControlBits(arrivalControlBits),
        .routeAckToggle(routeAckToggle), .irq(irq));
    ctrs_route_model #(.DW(24)) partner (.clock(clock), .rst(rst),
        .reqToggle(routeReqToggle), .data0(routeData0),
        .acb(arrivalControlBits), .delay(delay), .ackToggle(routeAckToggle),
        .gotData(gotData), .gotAcb(gotAcb), .gotCount(gotCount));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        if (errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            errors++;
            end_of_test();
        end
        @(posedge clock);
    endtask
    task automatic pulse(input logic ev, input logic [23:0] v,
                         input logic lv);
        captureValue <= v;
        inputLevel <= lv;
        captureEvent <= ev;
        timeoutEvent <= !ev;
        @(posedge clock);
        captureEvent <= 1'b0;
        timeoutEvent <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wait_bundles(input logic [7:0] k);
        int n = 0;
        while (gotCount !== k && n < 200) begin
            @(posedge clock);
            n++;
        end
        if (gotCount !== k) begin
            errors++;
            end_of_test();
        end
    endtask
    // ----
    // Scenarios
    // ----
    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        apb(1'b0, `CTRS_OFS_CTRL, 32'h0000_0000);
        chk(rd, `CTRS_CTRL_RESET);
        apb(1'b0, 12'h040, 32'h0000_0000);
        chk({er, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, `CTRS_OFS_NOTIFY, 32'h0000_001F);
        chk(er, 1'b1);
        pulse(1'b1, 24'h00_00AA, 1'b1);
        repeat (8) @(posedge clock);
        chk(gotCount, 8'h00);
        apb(1'b1, `CTRS_OFS_CTRL, 32'h0000_0001);
        pulse(1'b1, 24'h12_3456, 1'b0);
        wait_bundles(8'h01);
        chk({gotAcb, gotData}, {3'h0, 24'h12_3456});
        // Let the synchronised ack retire the request
        repeat (4) @(posedge clock);
        delay <= 8'h1E;
        pulse(1'b1, 24'h00_0A0A, 1'b1);
        repeat (3) @(posedge clock);
        pulse(1'b1, 24'h00_0B0B, 1'b0);
        wait_bundles(8'h02);
        chk({gotAcb, gotData}, {3'h1, 24'h00_0A0A});
        wait_bundles(8'h03);
        chk({gotAcb, gotData}, {3'h2, 24'h00_0B0B});
        repeat (4) @(posedge clock);
        pulse(1'b0, 24'h00_0000, 1'b0);
        wait_bundles(8'h04);
        chk(gotAcb, 3'h4);
        apb(1'b0, `CTRS_OFS_NOTIFY, 32'h0000_0000);
        chk(rd & 32'h0000_0018, 32'h0000_0018);
        chk(irq, 1'b0);
        apb(1'b1, `CTRS_OFS_IRQ_EN, 32'h0000_0018);
        @(posedge clock);
        chk(irq, 1'b1);
        apb(1'b1, `CTRS_OFS_IRQ_CLR, 32'h0000_0018);
        @(posedge clock);
        chk(irq, 1'b0);
        apb(1'b1, `CTRS_OFS_CTRL, 32'h0000_0005);
        delay <= 8'h06;
        pulse(1'b1, 24'h00_0001, 1'b0);
        repeat (6) @(posedge clock);
        pulse(1'b1, 24'h00_0002, 1'b1);
        wait_bundles(8'h05);
        chk({gotAcb[0], gotData}, {1'b0, 24'h00_0000});
        wait_bundles(8'h06);
        chk({gotAcb[0], gotData}, {1'b1, 24'h00_0001});
        chk(routeData1, 24'h00_0002);
        end_of_test();
    end
endmodule
`default_nettype wire
